// [hdl/exec_subset_consts.svh]
// Constants for the instruction execution subset
`ifndef EXEC_SUBSET_CONSTS_SVH
`define EXEC_SUBSET_CONSTS_SVH
`define DATA_W          8
`define FILE_ADDR_W     7
`define DIR_SEL_PORT_A  3'h5
`define DIR_SEL_PORT_B  3'h6
`define DIR_SEL_PORT_C  3'h7
`define ACC_RESET       8'h00
`define DIR_RESET       8'hFF
`define WDOG_W          8
`define WDOG_CLEAR      8'h00
`define PRESC_W         8
`define PRESC_CLEAR     8'h00
`define FLAG_PD_RESET   1'b1
`define FLAG_TO_RESET   1'b1
`endif

// [hdl/exec_subset_pkg.sv]
// Types for the instruction execution subset
package exec_subset_pkg;
    typedef enum logic [2:0]
    {
        OP_NONE        = 3'b000,
        OP_SLEEP       = 3'b001,
        OP_SUB_FILE    = 3'b010,
        OP_SUB_BORROW  = 3'b011,
        OP_NIBBLE_EXCH = 3'b100,
        OP_XOR_LITERAL = 3'b101,
        OP_XOR_FILE    = 3'b110,
        OP_DIR_LOAD    = 3'b111
    } exec_op_t;

    typedef struct packed
    {
        logic carry;
        logic digit_carry;
        logic zero;
        logic power_down;
        logic timeout;
    } status_flags_t;

    typedef struct packed
    {
        logic       we;
        logic [6:0] addr;
        logic [7:0] data;
    } file_write_t;
endpackage

// [hdl/instruction_exec_subset.sv]
// Execution datapath for sleep, subtract, nibble exchange, xor and direction load
// Operation
// - Sleep clears the power-down flag and sets the time-out flag, touching no other flag.
// - Sleep zeroes the watchdog counter and its prescaler.
// - Sleep puts the core into its sleep state with the oscillator halted.
// - Subtract-from-file gives file minus accumulator with carry and digit carry as no-borrow.
// - With a destination bit, 0 sends the result to the accumulator and 1 to the file.
// - Subtract-with-borrow also subtracts the inverted carry and updates C, DC and Z.
// - Nibble exchange swaps the two nibbles of the file value and changes no flag.
// - Xor-literal xors the accumulator with the literal into the accumulator, Z only.
// - Xor-with-file xors accumulator and file to the chosen destination, Z only.
// - Direction load copies the accumulator to port A, B or C direction for 5, 6 or 7.
`timescale 1ns/1ps
`include "exec_subset_consts.svh"

module instruction_exec_subset
(
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic                          exec_valid,
    input  wire exec_subset_pkg::exec_op_t     exec_op,
    input  wire logic [`FILE_ADDR_W-1:0]       file_addr,
    input  wire logic [`DATA_W-1:0]            file_rdata,
    input  wire logic [`DATA_W-1:0]            literal,
    input  wire logic                          dest_file,
    input  wire logic                          wake_event,
    output logic [`DATA_W-1:0]                 acc_reg,
    output exec_subset_pkg::status_flags_t     flags_reg,
    output exec_subset_pkg::file_write_t       file_wr_reg,
    output logic [`DATA_W-1:0]                 port_a_direction_reg,
    output logic [`DATA_W-1:0]                 port_b_direction_reg,
    output logic [`DATA_W-1:0]                 port_c_direction_reg,
    output logic [`WDOG_W-1:0]                 watchdog_counter_reg,
    output logic [`PRESC_W-1:0]                watchdog_prescaler_reg,
    output logic                               sleep_reg,
    output logic                               osc_run_reg
);

    logic [`DATA_W-1:0]             acc_next;
    exec_subset_pkg::status_flags_t flags_next;
    exec_subset_pkg::file_write_t   file_wr_next;
    logic [`DATA_W-1:0]             port_a_direction_next;
    logic [`DATA_W-1:0]             port_b_direction_next;
    logic [`DATA_W-1:0]             port_c_direction_next;
    logic [`WDOG_W-1:0]             watchdog_counter_next;
    logic [`PRESC_W-1:0]            watchdog_prescaler_next;
    logic                           sleep_next;
    logic                           osc_run_next;

    logic [`DATA_W:0]               diff_full;
    logic [4:0]                     diff_low;
    logic                           borrow_in;
    logic [`DATA_W-1:0]             result;
    logic                           active;

    // Carry acts as not-borrow, so the borrow in is the inverted carry
    assign borrow_in = (exec_op == exec_subset_pkg::OP_SUB_BORROW) ? ~flags_reg.carry : 1'b0;
    // Ninth and fifth bits of the extended subtraction give the no-borrow flags
    assign diff_full = {1'b0, file_rdata} - {1'b0, acc_reg} - {8'h00, borrow_in};
    assign diff_low  = {1'b0, file_rdata[3:0]} - {1'b0, acc_reg[3:0]} - {4'h0, borrow_in};
    // Instructions are ignored while asleep; the clock would be stopped anyway
    assign active    = exec_valid && !sleep_reg;

    // Next-state computation for the whole datapath
    always_comb
    begin
        acc_next                = acc_reg;
        flags_next              = flags_reg;
        file_wr_next            = '0;
        port_a_direction_next   = port_a_direction_reg;
        port_b_direction_next   = port_b_direction_reg;
        port_c_direction_next   = port_c_direction_reg;
        watchdog_counter_next   = watchdog_counter_reg + 8'h01;
        // Prescaler steps every cycle; the real divide ratio lives outside this block
        watchdog_prescaler_next = watchdog_prescaler_reg + 8'h01;
        sleep_next              = sleep_reg;
        osc_run_next            = osc_run_reg;
        result                  = diff_full[`DATA_W-1:0];
        if (sleep_reg && wake_event)
        begin
            sleep_next   = 1'b0;
            osc_run_next = 1'b1;
        end
        if (active)
        begin
            unique case (exec_op)
                exec_subset_pkg::OP_SLEEP:
                begin
                    flags_next.power_down   = 1'b0;
                    flags_next.timeout      = 1'b1;
                    watchdog_counter_next   = `WDOG_CLEAR;
                    watchdog_prescaler_next = `PRESC_CLEAR;
                    sleep_next              = 1'b1;
                    osc_run_next            = 1'b0;
                end
                exec_subset_pkg::OP_SUB_FILE, exec_subset_pkg::OP_SUB_BORROW:
                begin
                    result                 = diff_full[`DATA_W-1:0];
                    flags_next.carry       = ~diff_full[`DATA_W];
                    flags_next.digit_carry = ~diff_low[4];
                    flags_next.zero        = (result == 8'h00);
                end
                exec_subset_pkg::OP_NIBBLE_EXCH:
                    result = {file_rdata[3:0], file_rdata[7:4]};
                exec_subset_pkg::OP_XOR_LITERAL:
                begin
                    result          = acc_reg ^ literal;
                    flags_next.zero = (result == 8'h00);
                end
                exec_subset_pkg::OP_XOR_FILE:
                begin
                    result          = acc_reg ^ file_rdata;
                    flags_next.zero = (result == 8'h00);
                end
                exec_subset_pkg::OP_DIR_LOAD:
                begin
                    // Operands other than 5 to 7 load nothing
                    if (file_addr[2:0] == `DIR_SEL_PORT_A && file_addr[6:3] == 4'h0)
                        port_a_direction_next = acc_reg;
                    if (file_addr[2:0] == `DIR_SEL_PORT_B && file_addr[6:3] == 4'h0)
                        port_b_direction_next = acc_reg;
                    if (file_addr[2:0] == `DIR_SEL_PORT_C && file_addr[6:3] == 4'h0)
                        port_c_direction_next = acc_reg;
                end
                default:
                    result = diff_full[`DATA_W-1:0];
            endcase
            // Destination steering: xor-literal to the accumulator, file-register forms by dest_file
            if (exec_op == exec_subset_pkg::OP_XOR_LITERAL)
                acc_next = result;
            else if (exec_op == exec_subset_pkg::OP_SUB_FILE
                     || exec_op == exec_subset_pkg::OP_SUB_BORROW
                     || exec_op == exec_subset_pkg::OP_NIBBLE_EXCH
                     || exec_op == exec_subset_pkg::OP_XOR_FILE)
            begin
                if (dest_file)
                begin
                    file_wr_next.we   = 1'b1;
                    file_wr_next.addr = file_addr;
                    file_wr_next.data = result;
                end
                else
                    acc_next = result;
            end
        end
    end

    // Register stage; every output comes from here
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            acc_reg                <= `ACC_RESET;
            flags_reg              <= '0;
            flags_reg.power_down   <= `FLAG_PD_RESET;
            flags_reg.timeout      <= `FLAG_TO_RESET;
            file_wr_reg            <= '0;
            port_a_direction_reg   <= `DIR_RESET;
            port_b_direction_reg   <= `DIR_RESET;
            port_c_direction_reg   <= `DIR_RESET;
            watchdog_counter_reg   <= `WDOG_CLEAR;
            watchdog_prescaler_reg <= `PRESC_CLEAR;
            sleep_reg              <= 1'b0;
            osc_run_reg            <= 1'b1;
        end
        else
        begin
            acc_reg                <= acc_next;
            flags_reg              <= flags_next;
            file_wr_reg            <= file_wr_next;
            port_a_direction_reg   <= port_a_direction_next;
            port_b_direction_reg   <= port_b_direction_next;
            port_c_direction_reg   <= port_c_direction_next;
            watchdog_counter_reg   <= watchdog_counter_next;
            watchdog_prescaler_reg <= watchdog_prescaler_next;
            sleep_reg              <= sleep_next;
            osc_run_reg            <= osc_run_next;
        end
    end

    // Sleep step followed by its visible effects
    sequence s_sleep_issue;
        active && exec_op == exec_subset_pkg::OP_SLEEP;
    endsequence
    sequence s_sleep_done;
        !flags_reg.power_down && flags_reg.timeout;
    endsequence

    property p_sleep_flags;
        @(posedge ref_clk) disable iff (rst)
        s_sleep_issue |=> s_sleep_done and ($stable(flags_reg.carry) && $stable(flags_reg.zero)
            && $stable(flags_reg.digit_carry));
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

    property p_sleep_wdog;
        @(posedge ref_clk) disable iff (rst)
        s_sleep_issue |=> watchdog_counter_reg == 8'h00 && watchdog_prescaler_reg == 8'h00;
    endproperty
    a_sleep_wdog: assert property (p_sleep_wdog) else $error("watchdog not cleared");

    property p_sleep_state;
        @(posedge ref_clk) disable iff (rst)
        s_sleep_issue |=> sleep_reg && !osc_run_reg;
    endproperty
    a_sleep_state: assert property (p_sleep_state) else $error("sleep not entered");

    property p_sub_file;
        @(posedge ref_clk) disable iff (rst)
        active && exec_op == exec_subset_pkg::OP_SUB_FILE && !dest_file |=>
            acc_reg == $past(file_rdata) - $past(acc_reg)
            && flags_reg.carry == ($past(acc_reg) <= $past(file_rdata))
            && flags_reg.digit_carry == ($past(acc_reg[3:0]) <= $past(file_rdata[3:0]));
    endproperty
    a_sub_file: assert property (p_sub_file) else $error("subtract wrong");

    property p_dest_file;
        @(posedge ref_clk) disable iff (rst)
        active && dest_file && exec_op == exec_subset_pkg::OP_XOR_FILE |=>
            file_wr_reg.we && file_wr_reg.addr == $past(file_addr) && $stable(acc_reg);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("destination wrong");

    property p_sub_borrow;
        @(posedge ref_clk) disable iff (rst)
        active && exec_op == exec_subset_pkg::OP_SUB_BORROW && !dest_file |=>
            acc_reg == $past(file_rdata) - $past(acc_reg) - {7'h00, ~$past(flags_reg.carry)};
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("borrow subtract wrong");

    property p_nibble;
        @(posedge ref_clk) disable iff (rst)
        active && exec_op == exec_subset_pkg::OP_NIBBLE_EXCH && dest_file |=>
            file_wr_reg.data == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}
            && $stable(flags_reg);
    endproperty
    a_nibble: assert property (p_nibble) else $error("nibble exchange wrong");

    property p_xor_lit;
        @(posedge ref_clk) disable iff (rst)
        active && exec_op == exec_subset_pkg::OP_XOR_LITERAL |=>
            acc_reg == ($past(acc_reg) ^ $past(literal)) && $stable(flags_reg.carry)
            && flags_reg.zero == (acc_reg == 8'h00);
    endproperty
    a_xor_lit: assert property (p_xor_lit) else $error("xor literal wrong");

    property p_xor_file;
        @(posedge ref_clk) disable iff (rst)
        active && exec_op == exec_subset_pkg::OP_XOR_FILE && !dest_file |=>
            acc_reg == ($past(acc_reg) ^ $past(file_rdata)) && $stable(flags_reg.digit_carry);
    endproperty
    a_xor_file: assert property (p_xor_file) else $error("xor file wrong");

    property p_dir_b;
        @(posedge ref_clk) disable iff (rst)
        active && exec_op == exec_subset_pkg::OP_DIR_LOAD && file_addr == 7'h06 |=>
            port_b_direction_reg == $past(acc_reg) && $stable(port_a_direction_reg)
            && $stable(flags_reg);
    endproperty
    a_dir_b: assert property (p_dir_b) else $error("direction load wrong");

endmodule

// [verification/instruction_exec_subset_tb.sv]
// Self-checking bench for the instruction execution subset
`timescale 1ns/1ps
`include "exec_subset_consts.svh"

module instruction_exec_subset_tb;
    logic                           ref_clk, rst, exec_valid, dest_file, wake_event;
    exec_subset_pkg::exec_op_t      exec_op;
    logic [`FILE_ADDR_W-1:0]        file_addr;
    logic [`DATA_W-1:0]             file_rdata, literal, acc_reg, da, db, dc, acc_m;
    exec_subset_pkg::status_flags_t flags_reg, fl_m;
    exec_subset_pkg::file_write_t   file_wr_reg;
    logic [`DATA_W-1:0]             port_a_direction_reg, port_b_direction_reg;
    logic [`DATA_W-1:0]             port_c_direction_reg;
    logic [`WDOG_W-1:0]             watchdog_counter_reg;
    logic [`PRESC_W-1:0]            watchdog_prescaler_reg;
    logic                           sleep_reg, osc_run_reg, asleep_m;
    int                             mismatches, total_checks;

    instruction_exec_subset u_dut (.ref_clk(ref_clk), .rst(rst), .exec_valid(exec_valid),
        .exec_op(exec_op), .file_addr(file_addr), .file_rdata(file_rdata), .literal(literal),
        .dest_file(dest_file), .wake_event(wake_event), .acc_reg(acc_reg),
        .flags_reg(flags_reg), .file_wr_reg(file_wr_reg),
        .port_a_direction_reg(port_a_direction_reg), .port_b_direction_reg(port_b_direction_reg),
        .port_c_direction_reg(port_c_direction_reg), .watchdog_counter_reg(watchdog_counter_reg),
        .watchdog_prescaler_reg(watchdog_prescaler_reg), .sleep_reg(sleep_reg),
        .osc_run_reg(osc_run_reg));

    // 10 MHz instruction clock
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Issues one op, predicts it from the bench model, then checks all outputs, file write address and data only on a write, watchdog pair only after sleep
    task automatic run(input exec_subset_pkg::exec_op_t op, input logic [6:0] a,
                       input logic [7:0] f, input logic [7:0] k, input logic d);
        logic [7:0] res;
        logic       upd_z, to_file, b;
        @(negedge ref_clk);
        exec_valid = 1'b1;
        exec_op    = op;
        file_addr  = a;
        file_rdata = f;
        literal    = k;
        dest_file  = d;
        res        = acc_m;
        upd_z      = 1'b0;
        to_file    = 1'b0;
        // Plain subtract ignores carry in; borrow variant takes the inverted carry
        b = (op == exec_subset_pkg::OP_SUB_BORROW) ? ~fl_m.carry : 1'b0;
        if (!asleep_m)
            case (op)
                exec_subset_pkg::OP_SUB_FILE, exec_subset_pkg::OP_SUB_BORROW:
                begin
                    res = f - acc_m - b;
                    fl_m.carry = {1'b0, f} >= ({1'b0, acc_m} + 9'(b));
                    fl_m.digit_carry = {1'b0, f[3:0]} >= ({1'b0, acc_m[3:0]} + 5'(b));
                    upd_z = 1'b1;
                    to_file = d;
                end
                exec_subset_pkg::OP_NIBBLE_EXCH: {res, to_file} = {f[3:0], f[7:4], d};
                exec_subset_pkg::OP_XOR_LITERAL: {res, upd_z} = {acc_m ^ k, 1'b1};
                exec_subset_pkg::OP_XOR_FILE:    {res, upd_z, to_file} = {acc_m ^ f, 1'b1, d};
                exec_subset_pkg::OP_DIR_LOAD:
                begin
                    if (a == 7'h05) da = acc_m;
                    if (a == 7'h06) db = acc_m;
                    if (a == 7'h07) dc = acc_m;
                end
                exec_subset_pkg::OP_SLEEP: {fl_m.power_down, fl_m.timeout, asleep_m} = 3'b011;
                default: ;
            endcase
        if (!to_file) acc_m = res;
        if (upd_z) fl_m.zero = (res == 8'h00);
        @(negedge ref_clk);
        exec_valid = 1'b0;
        chk("acc", acc_reg, acc_m);
        chk("flags", flags_reg, fl_m);
        chk("file_we", file_wr_reg.we, to_file);
        if (to_file) chk("file_wr", file_wr_reg[14:0], {a, res});
        chk("dirs", {port_a_direction_reg, port_b_direction_reg}, {da, db});
        chk("dir_c", port_c_direction_reg, dc);
        chk("sleep", {sleep_reg, osc_run_reg}, {asleep_m, ~asleep_m});
        if (op == exec_subset_pkg::OP_SLEEP)
            chk("wdog", {watchdog_counter_reg, watchdog_prescaler_reg}, 16'h0000);
    endtask

    task automatic t_reset();
        chk("rst_acc", acc_reg, `ACC_RESET);
        chk("rst_flags", flags_reg, {3'b000, `FLAG_PD_RESET, `FLAG_TO_RESET});
        chk("rst_fwr", file_wr_reg, 16'h0000);
        chk("rst_sleep", {sleep_reg, osc_run_reg}, 2'b01);
        $display("test reset done");
    endtask

    task automatic t_sub();
        run(exec_subset_pkg::OP_XOR_LITERAL, 7'h00, 8'h00, 8'h03, 1'b0);
        run(exec_subset_pkg::OP_SUB_FILE, 7'h10, 8'h05, 8'h00, 1'b0);
        run(exec_subset_pkg::OP_SUB_FILE, 7'h7F, 8'h01, 8'h00, 1'b1);
        run(exec_subset_pkg::OP_SUB_FILE, 7'h20, 8'h12, 8'h00, 1'b0);
        run(exec_subset_pkg::OP_SUB_FILE, 7'h20, 8'h10, 8'h00, 1'b0);
        $display("test subtract done");
    endtask

    task automatic t_borrow();
        // Carry is set on entry here and clear before the second borrow step
        run(exec_subset_pkg::OP_XOR_LITERAL, 7'h00, 8'h00, 8'h05, 1'b0);
        run(exec_subset_pkg::OP_SUB_BORROW, 7'h11, 8'h10, 8'h00, 1'b1);
        run(exec_subset_pkg::OP_SUB_FILE, 7'h11, 8'h00, 8'h00, 1'b1);
        run(exec_subset_pkg::OP_SUB_BORROW, 7'h12, 8'h06, 8'h00, 1'b0);
        run(exec_subset_pkg::OP_SUB_BORROW, 7'h12, 8'h00, 8'h00, 1'b0);
        $display("test borrow done");
    endtask

    task automatic t_swap_xor();
        run(exec_subset_pkg::OP_NIBBLE_EXCH, 7'h30, 8'hA5, 8'h00, 1'b0);
        run(exec_subset_pkg::OP_NIBBLE_EXCH, 7'h31, 8'h3C, 8'h00, 1'b1);
        run(exec_subset_pkg::OP_XOR_LITERAL, 7'h00, 8'h00, 8'hFF, 1'b0);
        run(exec_subset_pkg::OP_XOR_FILE, 7'h7F, 8'h0F, 8'h00, 1'b1);
        run(exec_subset_pkg::OP_XOR_FILE, 7'h40, acc_m, 8'h00, 1'b0);
        // Idle code with valid high must leave every register but the free-running watchdog pair, and the file, alone
        run(exec_subset_pkg::OP_NONE, 7'h05, 8'h12, 8'h34, 1'b1);
        $display("test swap and xor done");
    endtask

    task automatic t_dir();
        for (int i = 4; i < 8; i++)
        begin
            // A fresh accumulator per selector shows which register took it
            run(exec_subset_pkg::OP_XOR_LITERAL, 7'h00, 8'h00, 8'(8'h11 * i), 1'b0);
            run(exec_subset_pkg::OP_DIR_LOAD, 7'(i), 8'h00, 8'h00, 1'b0);
        end
        $display("test direction done");
    endtask

    task automatic t_sleep();
        run(exec_subset_pkg::OP_SLEEP, 7'h00, 8'h00, 8'h00, 1'b0);
        run(exec_subset_pkg::OP_XOR_LITERAL, 7'h00, 8'h00, 8'h5A, 1'b0);
        wake_event = 1'b1;
        @(negedge ref_clk);
        wake_event = 1'b0;
        asleep_m = 1'b0;
        chk("wake", {sleep_reg, osc_run_reg}, 2'b01);
        run(exec_subset_pkg::OP_XOR_LITERAL, 7'h00, 8'h00, 8'h5A, 1'b0);
        $display("test sleep done");
    endtask

    // Hang guard: a run far past its expected length counts as a mismatch
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        results();
    end

    // Main sequence: reset for 16 cycles, then the scenarios
    initial
    begin
        {rst, exec_valid, dest_file, wake_event, asleep_m} = 5'b10000;
        exec_op = exec_subset_pkg::OP_NONE;
        {file_addr, file_rdata, literal} = '0;
        {mismatches, total_checks} = '0;
        {acc_m, da, db, dc} = {`ACC_RESET, `DIR_RESET, `DIR_RESET, `DIR_RESET};
        fl_m = {3'b000, `FLAG_PD_RESET, `FLAG_TO_RESET};
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        t_reset();
        t_sub();
        t_borrow();
        t_swap_xor();
        t_dir();
        t_sleep();
        results();
    end
endmodule
